// [src/iowa_params.svh]
// Behaviour
// RQ1 - Reserve fixed words per dedicated unit
// RQ2 - Use switch-selected word count, analog 4/2
// RQ3 - Unallocated words stay free work words
// RQ4 - Word zero reserved for processor inputs
// RQ5 - Inputs from word one, outputs from 100
// RQ6 - Processor block first, then expansion block
// RQ7 - Linking units get no words
// RQ8 - Analog supply counted, gets no words
// RQ9 - Capacity 15 input/16 output or 15 total
// RQ10 - Overflow raises fatal error code E1
// RQ11 - Status low byte: input count BCD
// RQ12 - Status high byte: output count BCD
// RQ13 - No empty slots; lowest free words
// RQ14 - Input and output sequences independent
// RQ15 - Sensor with four modules takes five
// RQ16 - Whole words; eight-point input upper unusable
// RQ17 - Thirty-two point: A first, B next word
// RQ18 - Allocation settles before program execution
`ifndef IOWA_PARAMS_SVH
`define IOWA_PARAMS_SVH
`define IOWA_MAX_UNITS      16
`define IOWA_IN_BASE        8'h01
`define IOWA_OUT_BASE       8'h64
`define IOWA_CPU_WORD       8'h00
`define IOWA_LARGE_IN_CAP   5'h0F
`define IOWA_LARGE_OUT_CAP  5'h10
`define IOWA_SMALL_TOT_CAP  6'h0F
`define IOWA_ERR_E1         8'hE1
`define IOWA_ADDR_CTRL      8'h00
`define IOWA_ADDR_COUNTS    8'h04
`define IOWA_ADDR_STATUS    8'h08
`define IOWA_ADDR_IRQ_STAT  8'h0C
`define IOWA_ADDR_IRQ_MASK  8'h10
`define IOWA_ADDR_UNIT0     8'h40
`define IOWA_ADDR_MAP0      8'h80
`define IOWA_IRQ_DONE       0
`define IOWA_IRQ_OVF        1
`define IOWA_SENSOR_FULL    3'h4
`define IOWA_SENSOR_WORDS   5'h05
`endif

// [src/iowa_pkg.sv]
package iowa_pkg;
    typedef enum logic [2:0] {
        IOWA_K_EMPTY, IOWA_K_PLAIN, IOWA_K_LINK, IOWA_K_APS,
        IOWA_K_ANALOG, IOWA_K_SENSOR
    } iowa_kind_t;
    typedef struct packed {
        logic       valid;
        logic       expansion;
        iowa_kind_t kind;
        logic [2:0] in_words;
        logic [2:0] out_words;
        logic       sel_alt;
        logic [2:0] modules;
    } iowa_unit_t;
    typedef struct packed {
        logic [7:0] in_first;
        logic [7:0] out_first;
        logic [4:0] in_n;
        logic [4:0] out_n;
    } iowa_map_t;
    typedef enum logic [1:0] {IOWA_IDLE, IOWA_WALK, IOWA_DONE} iowa_st_t;
endpackage

// [src/iowa_bcd2.sv]
`timescale 1ns/1ps
`include "iowa_params.svh"
module iowa_bcd2
    import iowa_pkg::*;
(
    input  wire logic [4:0] bin,
    output wire logic [7:0] bcd
);
    wire logic       ge10;
    wire logic [4:0] low;
    assign ge10 = (bin >= 5'd10);
    assign low  = ge10 ? 5'(bin - 5'd10) : bin;
    assign bcd  = {3'h0, ge10, low[3:0]};
endmodule

// [src/iowa_alloc.sv]
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "iowa_params.svh"
module iowa_alloc
    import iowa_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output wire logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output wire logic        s_axi_wready,
    output wire logic [1:0]  s_axi_bresp,
    output wire logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output wire logic        s_axi_arready,
    output wire logic [31:0] s_axi_rdata,
    output wire logic [1:0]  s_axi_rresp,
    output wire logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        large_model,
    output wire logic        run_enable,
    output wire logic        fatal_error,
    output wire logic        irq
);
    localparam int N = `IOWA_MAX_UNITS;
    iowa_unit_t unit_r [N];
    iowa_map_t  map_r  [N];
    iowa_st_t   st_r;
    logic [4:0] idx_r;
    logic       pass_r;
    logic [4:0] in_cnt_r;
    logic [4:0] out_cnt_r;
    logic [3:0] unit_cnt_r;
    logic       ovf_r;
    logic [7:0] err_r;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_mask_r;
    logic       aw_held_r;
    logic       w_held_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic       bvalid_r;
    logic [1:0] bresp_r;
    logic       rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [15:0] counts_r;
    logic       rescan_r;

    // Per-unit word demand
    wire logic [2:0] need_in  [N];
    wire logic [2:0] need_out [N];
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_need
            iowa_unit_t u;
            assign u = unit_r[g];
            // Empty slots, link units and analog supply take nothing
            assign need_in[g] = (!u.valid || u.kind == IOWA_K_EMPTY ||
                                 u.kind == IOWA_K_LINK || // [RQ7] [RQ8] [RQ13]
                                 u.kind == IOWA_K_APS) ? 3'h0 :
                (u.kind == IOWA_K_ANALOG) ?
                    (u.sel_alt ? 3'h2 : 3'h4) : // [RQ2]
                (u.kind == IOWA_K_SENSOR) ?
                    ((u.modules >= `IOWA_SENSOR_FULL) ? 3'h5 :
                     3'(u.modules + 3'h1)) : // [RQ15]
                u.in_words; // [RQ1] [RQ16] [RQ17]
            assign need_out[g] = (!u.valid || u.kind == IOWA_K_EMPTY ||
                                  u.kind == IOWA_K_LINK ||
                                  u.kind == IOWA_K_APS ||
                                  u.kind == IOWA_K_ANALOG ||
                                  u.kind == IOWA_K_SENSOR) ? 3'h0 :
                                 u.out_words; // [RQ1] [RQ14]
        end
    endgenerate

    // Walk order: processor-block units on pass 0, expansion on pass 1
    wire logic [3:0] cur;
    wire logic       take;
    wire logic [4:0] add_in;
    wire logic [4:0] add_out;
    wire logic [5:0] in_sum;
    wire logic [5:0] out_sum;
    wire logic       walking;
    wire logic       ovf_now;
    assign cur     = idx_r[3:0];
    assign walking = (st_r == IOWA_WALK);
    assign take    = walking && unit_r[cur].valid &&
                     (unit_r[cur].expansion == pass_r); // [RQ6]
    assign add_in  = take ? {2'h0, need_in[cur]} : 5'h0;
    assign add_out = take ? {2'h0, need_out[cur]} : 5'h0;
    assign in_sum  = {1'b0, in_cnt_r} + {1'b0, add_in};
    assign out_sum = {1'b0, out_cnt_r} + {1'b0, add_out};
    // Input word zero does not count against the unit capacity
    assign ovf_now = large_model ?
        ((in_sum > {1'b0, `IOWA_LARGE_IN_CAP}) ||
         (out_sum > {1'b0, `IOWA_LARGE_OUT_CAP})) :
        ((6'(in_sum + out_sum)) > `IOWA_SMALL_TOT_CAP); // [RQ4] [RQ9]

    wire logic       start_w;
    wire logic       last_w;
    assign start_w = (st_r == IOWA_IDLE);
    assign last_w  = walking && (idx_r == 5'(N - 1)) && pass_r;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r <= IOWA_IDLE;
            idx_r <= 5'h0;
            pass_r <= 1'b0;
            in_cnt_r <= 5'h0;
            out_cnt_r <= 5'h0;
            unit_cnt_r <= 4'h0;
            ovf_r <= 1'b0;
        end else if (start_w || rescan_r) begin
            st_r <= IOWA_WALK;
            idx_r <= 5'h0;
            pass_r <= 1'b0;
            in_cnt_r <= 5'h0;
            out_cnt_r <= 5'h0;
            unit_cnt_r <= 4'h0;
            ovf_r <= 1'b0;
        end else if (walking) begin
            in_cnt_r <= in_sum[4:0]; // [RQ5] [RQ13]
            out_cnt_r <= out_sum[4:0]; // [RQ14]
            if (take)
                unit_cnt_r <= 4'(unit_cnt_r + 4'h1); // [RQ8]
            if (take && ovf_now)
                ovf_r <= 1'b1; // [RQ10]
            if (idx_r == 5'(N - 1)) begin
                idx_r <= 5'h0;
                pass_r <= 1'b1;
                if (pass_r)
                    st_r <= IOWA_DONE; // [RQ18]
            end else begin
                idx_r <= 5'(idx_r + 5'h1);
            end
        end
    end

    // Address map per unit; unmapped words stay free
    always_ff @(posedge ref_clk) begin
        if (!rst_n || rescan_r) begin
            for (int i = 0; i < N; i++)
                map_r[i] <= '0;
        end else if (take) begin
            map_r[cur].in_first  <= 8'(`IOWA_IN_BASE + in_cnt_r); // [RQ5]
            map_r[cur].out_first <= 8'(`IOWA_OUT_BASE + out_cnt_r);
            map_r[cur].in_n      <= add_in; // [RQ3]
            map_r[cur].out_n     <= add_out;
        end
    end

    wire logic [7:0] in_bcd;
    wire logic [7:0] out_bcd;
    iowa_bcd2 u_bcd_in (
        .bin (5'(in_sum[4:0] + 5'h1)),
        .bcd (in_bcd)
    );
    iowa_bcd2 u_bcd_out (
        .bin (out_sum[4:0]),
        .bcd (out_bcd)
    );

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            counts_r <= 16'h0000;
            err_r <= 8'h00;
        end else if (last_w) begin
            counts_r <= {out_bcd, in_bcd}; // [RQ11] [RQ12]
            err_r <= (ovf_r || (take && ovf_now)) ? `IOWA_ERR_E1 : 8'h00;
        end
    end

    assign run_enable  = (st_r == IOWA_DONE) && (err_r == 8'h00); // [RQ18]
    assign fatal_error = (st_r == IOWA_DONE) && (err_r != 8'h00); // [RQ10]

    // AXI4-Lite slave
    wire logic       wr_go;
    wire logic [7:0] wa;
    wire logic       wa_ctrl;
    wire logic       wa_istat;
    wire logic       wa_imask;
    wire logic       wa_unit;
    wire logic       wr_ok;
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready  = !w_held_r && !bvalid_r;
    assign wr_go    = aw_held_r && w_held_r && !bvalid_r;
    assign wa       = awaddr_r;
    assign wa_ctrl  = (wa == `IOWA_ADDR_CTRL);
    assign wa_istat = (wa == `IOWA_ADDR_IRQ_STAT);
    assign wa_imask = (wa == `IOWA_ADDR_IRQ_MASK);
    assign wa_unit  = (wa[7:6] == 2'h1) && (wa[1:0] == 2'h0);
    assign wr_ok    = wa_ctrl || wa_istat || wa_imask || wa_unit ||
                      (wa == `IOWA_ADDR_COUNTS) ||
                      (wa == `IOWA_ADDR_STATUS);
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp  = bresp_r;

    wire logic       rescan;
    assign rescan = wr_go && wa_ctrl && wstrb_r[0] && wdata_r[0];

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_ok ? 2'h0 : 2'h2;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Unit table written by software at any time, even while the walk runs
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < N; i++)
                unit_r[i] <= '0;
            irq_mask_r <= 2'h0;
        end else if (wr_go) begin
            if (wa_unit && wstrb_r[1] && wstrb_r[0])
                unit_r[wa[5:2]] <= iowa_unit_t'(wdata_r[14:0]);
            if (wa_imask && wstrb_r[0])
                irq_mask_r <= wdata_r[1:0];
        end
    end

    // Sticky events; a set in the clearing cycle wins
    wire logic [1:0] ev;
    wire logic [1:0] clr;
    assign ev  = last_w ? {(ovf_r || (take && ovf_now)), 1'b1} : 2'h0;
    assign clr = (wr_go && wa_istat && wstrb_r[0]) ? wdata_r[1:0] : 2'h0;
    always_ff @(posedge ref_clk) begin
        if (!rst_n)
            irq_stat_r <= 2'h0;
        else
            irq_stat_r <= (irq_stat_r & ~clr) | ev;
    end
    assign irq = |(irq_stat_r & irq_mask_r);

    // Restart of the walk on software request, taken only in IOWA_DONE
    always_ff @(posedge ref_clk) begin
        if (!rst_n)
            rescan_r <= 1'b0;
        else
            rescan_r <= rescan && (st_r == IOWA_DONE);
    end

    wire logic [7:0]  ra;
    wire logic [31:0] rd_mux;
    wire logic        rd_ok;
    wire logic        ra_map;
    wire logic        ra_unit;
    iowa_map_t        mp;
    assign ra      = s_axi_araddr[7:0];
    assign ra_map  = (ra[7:6] == 2'h2) && (ra[1:0] == 2'h0);
    assign ra_unit = (ra[7:6] == 2'h1) && (ra[1:0] == 2'h0);
    assign mp      = map_r[ra[5:2]];
    assign rd_ok   = ra_map || ra_unit || (ra == `IOWA_ADDR_CTRL) ||
                     (ra == `IOWA_ADDR_COUNTS) ||
                     (ra == `IOWA_ADDR_STATUS) ||
                     (ra == `IOWA_ADDR_IRQ_STAT) ||
                     (ra == `IOWA_ADDR_IRQ_MASK);
    assign rd_mux =
        (ra == `IOWA_ADDR_COUNTS) ? {16'h0, counts_r} :
        (ra == `IOWA_ADDR_STATUS) ? {16'h0, unit_cnt_r, err_r,
                                     run_enable, fatal_error,
                                     (st_r == IOWA_DONE), walking} :
        (ra == `IOWA_ADDR_IRQ_STAT) ? {30'h0, irq_stat_r} :
        (ra == `IOWA_ADDR_IRQ_MASK) ? {30'h0, irq_mask_r} :
        ra_unit ? {17'h0, unit_r[ra[5:2]]} :
        ra_map ? {8'h0, mp.out_n[2:0], mp.in_n[2:0], mp.out_first,
                  mp.in_first, 2'h0} :
        32'h0;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= 2'h0;
        end else if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= rd_ok ? 2'h0 : 2'h2;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    counts_settle_a: assert property ( // [RQ11]
        @(posedge ref_clk) disable iff (!rst_n)
        last_w |=> counts_r[7:0] == $past(in_bcd))
        else $error("input count not published");
    run_gate_a: assert property ( // [RQ18]
        @(posedge ref_clk) disable iff (!rst_n)
        run_enable |-> st_r == IOWA_DONE && err_r == 8'h00)
        else $error("run before allocation settled");
    err_code_a: assert property ( // [RQ10]
        @(posedge ref_clk) disable iff (!rst_n)
        fatal_error |-> err_r == 8'hE1)
        else $error("fatal error without E1");
    link_none_a: assert property ( // [RQ7]
        @(posedge ref_clk) disable iff (!rst_n)
        take && unit_r[cur].kind == IOWA_K_LINK |=> in_cnt_r ==
        $past(in_cnt_r) && out_cnt_r == $past(out_cnt_r))
        else $error("link unit received words");
    aps_count_a: assert property ( // [RQ8]
        @(posedge ref_clk) disable iff (!rst_n)
        take && unit_r[cur].kind == IOWA_K_APS |=>
        unit_cnt_r == 4'($past(unit_cnt_r) + 4'h1))
        else $error("analog supply not counted");
    analog_sel_a: assert property ( // [RQ2]
        @(posedge ref_clk) disable iff (!rst_n)
        take && unit_r[cur].kind == IOWA_K_ANALOG && !unit_r[cur].sel_alt
        |=> in_cnt_r == 5'($past(in_cnt_r) + 5'h4))
        else $error("analog four-channel count wrong");
    sensor_five_a: assert property ( // [RQ15]
        @(posedge ref_clk) disable iff (!rst_n)
        take && unit_r[cur].kind == IOWA_K_SENSOR &&
        unit_r[cur].modules == 3'h4 |=>
        in_cnt_r == 5'($past(in_cnt_r) + 5'h5))
        else $error("sensor unit not five words");
    out_base_a: assert property ( // [RQ5]
        @(posedge ref_clk) disable iff (!rst_n)
        take |=> map_r[$past(cur)].out_first ==
        8'(8'h64 + $past(out_cnt_r)))
        else $error("output word not consecutive from 100");
    pass_order_a: assert property ( // [RQ6]
        @(posedge ref_clk) disable iff (!rst_n)
        walking && pass_r && !unit_r[cur].expansion |=>
        in_cnt_r == $past(in_cnt_r) && out_cnt_r == $past(out_cnt_r))
        else $error("processor unit taken on expansion pass");
endmodule

// [tb/iowa_unit_rack.sv]
`timescale 1ns/1ps
module iowa_unit_rack
    import iowa_pkg::*;
(
    input  wire logic [3:0] idx,
    output iowa_unit_t      unit
);
    // Mounted units in slot order, plain units declaring their own word demand
    always_comb begin
        unit = '0;
        case (idx)
            4'h0: unit = '{1'b1, 1'b0, IOWA_K_PLAIN, 3'h1, 3'h0,
                           1'b0, 3'h0};
            4'h1: unit = '{1'b1, 1'b0, IOWA_K_PLAIN, 3'h0, 3'h2,
                           1'b0, 3'h0};
            4'h2: unit = '{1'b1, 1'b0, IOWA_K_LINK, 3'h0, 3'h0,
                           1'b0, 3'h0};
            4'h3: unit = '{1'b1, 1'b1, IOWA_K_ANALOG, 3'h2, 3'h0,
                           1'b1, 3'h0};
            4'h4: unit = '{1'b1, 1'b1, IOWA_K_APS, 3'h0, 3'h0,
                           1'b0, 3'h0};
            4'h5: unit = '{1'b1, 1'b1, IOWA_K_SENSOR, 3'h0, 3'h0,
                           1'b0, 3'h4};
            4'h6: unit = '{1'b1, 1'b1, IOWA_K_PLAIN, 3'h1, 3'h0,
                           1'b0, 3'h0};
            default: unit = '0;
        endcase
    end
endmodule

// [tb/io_word_allocator_tb.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
 $display("Error %s expected %h seen %h", nm, e, g); end end
module io_word_allocator_tb
    import iowa_pkg::*;
;
    logic        ref_clk, rst_n, large_model;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready;
    logic [3:0]  s_axi_wstrb;
    wire  logic  s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire  logic  s_axi_arready, s_axi_rvalid;
    wire  logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire  logic [31:0] s_axi_rdata;
    wire  logic  run_enable, fatal_error, irq;
    logic [3:0]  rack_idx;
    iowa_unit_t  rack_unit, u;
    logic [31:0] seed, d;
    logic [1:0]  r;
    logic [14:0] sh [16];
    logic [31:0] em [16];
    logic        ovf;
    int          failures, cmp_count, cycles, ic, oc, nu, ni, no;

    iowa_alloc iowa_alloc_inst (
        .ref_clk(ref_clk), .rst_n(rst_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .large_model(large_model),
        .run_enable(run_enable), .fatal_error(fatal_error), .irq(irq)
    );
    iowa_unit_rack iowa_unit_rack_inst (.idx(rack_idx), .unit(rack_unit));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Two-digit BCD of a word count
    function automatic logic [7:0] bcd2(input int v);
        return 8'((v / 10) * 16 + (v % 10));
    endfunction

    task automatic final_report;
        $display("Comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            final_report;
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      output logic [1:0] rs);
        logic aw_d, w_d;
        aw_d = 1'b0;
        w_d = 1'b0;
        @(posedge ref_clk);
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_d && w_d)) begin
            @(posedge ref_clk);
            if (!aw_d && s_axi_awready) begin
                aw_d = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_d && s_axi_wready) begin
                w_d = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge ref_clk); while (!s_axi_bvalid);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v,
                      output logic [1:0] rs);
        logic ar_d;
        ar_d = 1'b0;
        @(posedge ref_clk);
        s_axi_araddr <= {24'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (!ar_d && s_axi_arready) begin
                ar_d = 1'b1;
                s_axi_arvalid <= 1'b0;
            end
        end while (!(ar_d && s_axi_rvalid));
        v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic wait_done;
        int k;
        k = 0;
        while (run_enable !== 1'b1 && fatal_error !== 1'b1 && k < 200) begin
            @(posedge ref_clk);
            k++;
        end
    endtask

    initial begin
        failures = 0;
        cmp_count = 0;
        cycles = 0;
        seed = 32'h4763DE5B;
        rst_n = 1'b0;
        large_model = 1'b1;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        rack_idx = 4'h0;
        for (int p = 0; p < 2; p++) begin
            @(posedge ref_clk);
            rst_n <= 1'b0;
            large_model <= (p == 0);
            repeat (16) @(posedge ref_clk);
            rst_n <= 1'b1;
            @(posedge ref_clk);
            #1 `CHK("run_early", 1'b0, run_enable)
            wait_done;
            `CHK("run_enable", 1'b1, run_enable)
            `CHK("fatal_error", 1'b0, fatal_error)
            rd(8'h04, d, r);
            // Empty table: only the processor word is allocated
            `CHK("count_in", bcd2(1), d[7:0])
            `CHK("count_out", bcd2(0), d[15:8])
            wr(8'h04, 32'hFFFF_FFFF, r);
            rd(8'h04, d, r);
            `CHK("count_ro", 16'h0001, d[15:0])
            rd(8'h08, d, r);
            `CHK("status_flags", 4'hA, d[3:0])
            `CHK("status_err", 8'h00, d[11:4])
            rd(8'h40, d, r);
            `CHK("unit_cleared", 32'h0, d)
            rd(8'h0C, d, r);
            `CHK("irq_stat", 2'h1, d[1:0])
            `CHK("irq_masked", 1'b0, irq)
            wr(8'h10, 32'h3, r);
            `CHK("irq_raised", 1'b1, irq)
            wr(8'h0C, 32'h1, r);
            `CHK("irq_cleared", 1'b0, irq)
            rd(8'h0C, d, r);
            `CHK("irq_stat_clr", 2'h0, d[1:0])
            wr(8'h10, 32'h0, r);
            wr(8'h3C, 32'h1234_5678, r);
            `CHK("unmapped_wr", 2'h2, r)
            rd(8'h3C, d, r);
            `CHK("unmapped_rd", 2'h2, r)
            for (int i = 0; i < 16; i++) begin
                rack_idx <= 4'(i);
                @(posedge ref_clk);
                u = rack_unit;
                if (p == 1) begin
                    seed = xs(seed);
                    u = seed[14:0];
                    u.kind = iowa_kind_t'(seed[22:20] % 3'h6);
                end
                sh[i] = u;
                wr(8'h40 + 8'(4 * i), {17'h0, u}, r);
            end
            for (int i = 0; i < 16; i++) begin
                rd(8'h40 + 8'(4 * i), d, r);
                `CHK("unit_table", {17'h0, sh[i]}, d)
            end
            // Reference walk: processor block first, then expansion
            ic = 0;
            oc = 0;
            nu = 0;
            for (int i = 0; i < 16; i++)
                em[i] = 32'h0;
            for (int b = 0; b < 2; b++) begin
                for (int i = 0; i < 16; i++) begin
                    u = sh[i];
                    if (u.valid && u.expansion == b) begin
                        ni = 0;
                        no = 0;
                        case (u.kind)
                            IOWA_K_PLAIN: begin
                                ni = u.in_words;
                                no = u.out_words;
                            end
                            IOWA_K_ANALOG: ni = u.sel_alt ? 2 : 4;
                            IOWA_K_SENSOR: ni = u.modules > 3 ? 5 : u.modules + 1;
                            default: ni = 0;
                        endcase
                        em[i] = {8'h00, 3'(no), 3'(ni), 8'(8'h64 + oc % 32),
                                 8'(8'h01 + ic % 32), 2'h0};
                        ic += ni;
                        oc += no;
                        nu++;
                    end
                end
            end
            if (p == 0)
                ovf = (ic > 15) || (oc > 16);
            else
                ovf = (ic + oc > 15);
            // Software asks for a fresh walk over the loaded table
            wr(8'h00, 32'h1, r);
            repeat (2) @(posedge ref_clk);
            wait_done;
            `CHK("run_after", !ovf, run_enable)
            `CHK("fatal_after", ovf, fatal_error)
            rd(8'h08, d, r);
            `CHK("unit_count", 4'(nu), d[15:12])
            `CHK("err_code", ovf ? 8'hE1 : 8'h00, d[11:4])
            rd(8'h04, d, r);
            if (!ovf) begin
                `CHK("alloc_in", bcd2(ic + 1), d[7:0])
                `CHK("alloc_out", bcd2(oc), d[15:8])
            end
            for (int i = 0; i < 16; i++) begin
                rd(8'h80 + 8'(4 * i), d, r);
                `CHK("unit_map", em[i], d)
            end
            rd(8'h0C, d, r);
            `CHK("irq_after", {ovf, 1'b1}, d[1:0])
        end
        final_report;
    end
endmodule
